/* logic/mbs_defs.svh */
`ifndef MBS_DEFS_SVH
`define MBS_DEFS_SVH

// Register byte offsets.
`define MBS_OFS_CTRL 8'h00
`define MBS_OFS_ON_REL 8'h04
`define MBS_OFS_REL_MOVE 8'h08
`define MBS_OFS_STOP_CLAMP 8'h0C
`define MBS_OFS_CLAMP_OFF 8'h10
`define MBS_OFS_STATUS 8'h14

// Control register fields.
`define MBS_CTRL_BRAKE_EN 0
`define MBS_CTRL_PWROFF_EN 1
`define MBS_CTRL_MOVE_REQ 2
`define MBS_CTRL_W 3
`define MBS_CTRL_RST 3'h3

// Status register fields.
`define MBS_STAT_RELEASE 0
`define MBS_STAT_POWER 1
`define MBS_STAT_PERMIT 2
`define MBS_STAT_STATE_LSB 8
`define MBS_STAT_STATE_MSB 11
`define MBS_STAT_CNT_LSB 16
`define MBS_STAT_CNT_MSB 31

// Delay registers, in milliseconds.
`define MBS_DLY_W 16
`define MBS_DLY_RST 16'h000A
`define MBS_CNT_SAT 16'hFFFF

// Millisecond tick period in microseconds.
`define MBS_TICK_PERIOD_US 1000
`define MBS_US_PER_S 1000000

// AXI4-Lite responses.
`define MBS_RESP_OKAY 2'h0
`define MBS_RESP_SLVERR 2'h2

`endif

/* logic/mbs_pkg.sv */
package mbs_pkg;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } mbs_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } mbs_axil_rsp_t;

    typedef enum logic [3:0] {
        MBS_ST_STOP = 4'h1,
        MBS_ST_START = 4'h2,
        MBS_ST_RUN = 4'h4,
        MBS_ST_HALT = 4'h8
    } mbs_state_t;

endpackage

/* logic/mbs_ms_tick.sv */
`timescale 1ns/1ps
module mbs_ms_tick #(
    parameter int unsigned PERIOD_CYC = 10000
) (
    input wire logic clk_sys,
    input wire logic rst,
    output logic tick
);
    localparam int unsigned CW = (PERIOD_CYC > 1) ? $clog2(PERIOD_CYC) : 1;
    localparam logic [CW-1:0] LAST = CW'(PERIOD_CYC - 1);

    logic [CW-1:0] div_r;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            div_r <= '0;
            tick <= 1'b0;
        end else if (div_r == LAST) begin
            div_r <= '0;
            tick <= 1'b1;
        end else begin
            div_r <= div_r + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule

/* logic/magnetic_brake_sequencer.sv */
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "mbs_defs.svh"
module magnetic_brake_sequencer #(
    parameter int unsigned CLK_HZ = 10000000,
    parameter int unsigned TICK_CYC = CLK_HZ / `MBS_US_PER_S * `MBS_TICK_PERIOD_US
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire mbs_pkg::mbs_axil_req_t axiReq,
    output mbs_pkg::mbs_axil_rsp_t axiRsp,
    input wire logic motorStopped,
    output logic brakeRelease,
    output logic windingPower,
    output logic motionPermit
);
    logic msTick;
    logic [`MBS_CTRL_W-1:0] ctrl_r;
    logic [`MBS_DLY_W-1:0] dlyOnRel_r;
    logic [`MBS_DLY_W-1:0] dlyRelMove_r;
    logic [`MBS_DLY_W-1:0] dlyStopClamp_r;
    logic [`MBS_DLY_W-1:0] dlyClampOff_r;
    mbs_pkg::mbs_state_t state_r;
    logic [`MBS_DLY_W-1:0] elapsed_r;
    logic pwrWasOn_r;
    logic brakeEn;
    logic pwrOffEn;
    logic moveReq;
    logic [`MBS_DLY_W:0] relAt;
    logic [`MBS_DLY_W:0] permitAt;
    logic [`MBS_DLY_W:0] offAt;
    logic [`MBS_DLY_W:0] elapsedWide;
    logic brakeRelease_nxt;
    logic windingPower_nxt;
    logic motionPermit_nxt;

    logic awHeld_r;
    logic wHeld_r;
    logic [7:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic bValid_r;
    logic [1:0] bResp_r;
    logic arRdy_r;
    logic rValid_r;
    logic [31:0] rData_r;
    logic [1:0] rResp_r;
    logic doWrite;
    logic wrHit;
    logic [31:0] rdData;
    logic rdHit;

    mbs_ms_tick #(
        .PERIOD_CYC(TICK_CYC)
    ) uTick (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(msTick)
    );

    assign brakeEn = ctrl_r[`MBS_CTRL_BRAKE_EN];
    assign pwrOffEn = ctrl_r[`MBS_CTRL_PWROFF_EN];
    assign moveReq = ctrl_r[`MBS_CTRL_MOVE_REQ];
    assign elapsedWide = {1'b0, elapsed_r};

    // With windings already powered there is no power-on wait before release.
    assign relAt = pwrWasOn_r ? '0 : {1'b0, dlyOnRel_r};
    assign permitAt = relAt + {1'b0, dlyRelMove_r};
    assign offAt = {1'b0, dlyStopClamp_r} + {1'b0, dlyClampOff_r};

    // Outputs are recomputed every cycle from live settings and registered, so edits reach the pins on the next cycle.
    always_comb begin
        brakeRelease_nxt = 1'b1;
        windingPower_nxt = 1'b1;
        motionPermit_nxt = 1'b0;
        case (state_r)
            mbs_pkg::MBS_ST_STOP: begin
                brakeRelease_nxt = !brakeEn || (elapsed_r < dlyStopClamp_r);
                windingPower_nxt = !pwrOffEn || (elapsedWide < offAt);
            end
            mbs_pkg::MBS_ST_START: begin
                brakeRelease_nxt = !brakeEn || (elapsedWide >= relAt);
                motionPermit_nxt = elapsedWide >= permitAt;
            end
            mbs_pkg::MBS_ST_RUN: begin
                motionPermit_nxt = 1'b1;
            end
            mbs_pkg::MBS_ST_HALT: begin
                motionPermit_nxt = 1'b0;
            end
            default: begin
                brakeRelease_nxt = 1'b0;
                windingPower_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r <= mbs_pkg::MBS_ST_STOP;
        end else begin
            case (state_r)
                mbs_pkg::MBS_ST_STOP: begin
                    if (moveReq) begin
                        state_r <= mbs_pkg::MBS_ST_START;
                    end
                end
                mbs_pkg::MBS_ST_START: begin
                    if (!moveReq) begin
                        state_r <= mbs_pkg::MBS_ST_HALT;
                    end else if (motionPermit_nxt) begin
                        state_r <= mbs_pkg::MBS_ST_RUN;
                    end
                end
                mbs_pkg::MBS_ST_RUN: begin
                    if (!moveReq) begin
                        state_r <= mbs_pkg::MBS_ST_HALT;
                    end
                end
                mbs_pkg::MBS_ST_HALT: begin
                    if (motorStopped) begin
                        state_r <= mbs_pkg::MBS_ST_STOP;
                    end
                end
                default: begin
                    state_r <= mbs_pkg::MBS_ST_STOP;
                end
            endcase
        end
    end

    // Elapsed milliseconds since the phase began; saturates instead of wrapping.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            elapsed_r <= `MBS_CNT_SAT;
        end else if ((state_r == mbs_pkg::MBS_ST_STOP) && moveReq) begin
            elapsed_r <= '0;
        end else if ((state_r == mbs_pkg::MBS_ST_HALT) && motorStopped) begin
            elapsed_r <= '0;
        end else if (msTick && (elapsed_r != `MBS_CNT_SAT)) begin
            elapsed_r <= elapsed_r + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pwrWasOn_r <= 1'b0;
        end else if ((state_r == mbs_pkg::MBS_ST_STOP) && moveReq) begin
            pwrWasOn_r <= windingPower;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            brakeRelease <= 1'b0;
            windingPower <= 1'b0;
            motionPermit <= 1'b0;
        end else begin
            brakeRelease <= brakeRelease_nxt;
            windingPower <= windingPower_nxt;
            motionPermit <= motionPermit_nxt;
        end
    end

    // Write address and data are taken independently and held until both are present.
    assign doWrite = awHeld_r && wHeld_r && !bValid_r;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            awHeld_r <= 1'b0;
            awAddr_r <= '0;
        end else if (!awHeld_r && axiReq.awvalid) begin
            awHeld_r <= 1'b1;
            awAddr_r <= axiReq.awaddr;
        end else if (doWrite) begin
            awHeld_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wHeld_r <= 1'b0;
            wData_r <= '0;
            wStrb_r <= '0;
        end else if (!wHeld_r && axiReq.wvalid) begin
            wHeld_r <= 1'b1;
            wData_r <= axiReq.wdata;
            wStrb_r <= axiReq.wstrb;
        end else if (doWrite) begin
            wHeld_r <= 1'b0;
        end
    end

    always_comb begin
        wrHit = 1'b1;
        if (awAddr_r == `MBS_OFS_CTRL) begin
            wrHit = 1'b1;
        end else if (awAddr_r == `MBS_OFS_ON_REL) begin
            wrHit = 1'b1;
        end else if (awAddr_r == `MBS_OFS_REL_MOVE) begin
            wrHit = 1'b1;
        end else if (awAddr_r == `MBS_OFS_STOP_CLAMP) begin
            wrHit = 1'b1;
        end else if (awAddr_r == `MBS_OFS_CLAMP_OFF) begin
            wrHit = 1'b1;
        end else if (awAddr_r == `MBS_OFS_STATUS) begin
            wrHit = 1'b1;
        end else begin
            wrHit = 1'b0;
        end
    end

    // Control bits; the sequencer follows enable changes on the next cycle.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_r <= `MBS_CTRL_RST;
        end else if (doWrite && (awAddr_r == `MBS_OFS_CTRL) && wStrb_r[0]) begin
            ctrl_r <= wData_r[`MBS_CTRL_W-1:0];
        end
    end

    // Delay registers may be rewritten at any time.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dlyOnRel_r <= `MBS_DLY_RST;
            dlyRelMove_r <= `MBS_DLY_RST;
            dlyStopClamp_r <= `MBS_DLY_RST;
            dlyClampOff_r <= `MBS_DLY_RST;
        end else if (doWrite) begin
            for (int b = 0; b < 2; b++) begin
                if (wStrb_r[b]) begin
                    if (awAddr_r == `MBS_OFS_ON_REL) begin
                        dlyOnRel_r[b*8 +: 8] <= wData_r[b*8 +: 8];
                    end else if (awAddr_r == `MBS_OFS_REL_MOVE) begin
                        dlyRelMove_r[b*8 +: 8] <= wData_r[b*8 +: 8];
                    end else if (awAddr_r == `MBS_OFS_STOP_CLAMP) begin
                        dlyStopClamp_r[b*8 +: 8] <= wData_r[b*8 +: 8];
                    end else if (awAddr_r == `MBS_OFS_CLAMP_OFF) begin
                        dlyClampOff_r[b*8 +: 8] <= wData_r[b*8 +: 8];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bValid_r <= 1'b0;
            bResp_r <= `MBS_RESP_OKAY;
        end else if (doWrite) begin
            bValid_r <= 1'b1;
            bResp_r <= wrHit ? `MBS_RESP_OKAY : `MBS_RESP_SLVERR;
        end else if (bValid_r && axiReq.bready) begin
            bValid_r <= 1'b0;
        end
    end

    always_comb begin
        rdData = '0;
        rdHit = 1'b1;
        if (axiReq.araddr == `MBS_OFS_CTRL) begin
            rdData[`MBS_CTRL_W-1:0] = ctrl_r;
        end else if (axiReq.araddr == `MBS_OFS_ON_REL) begin
            rdData[`MBS_DLY_W-1:0] = dlyOnRel_r;
        end else if (axiReq.araddr == `MBS_OFS_REL_MOVE) begin
            rdData[`MBS_DLY_W-1:0] = dlyRelMove_r;
        end else if (axiReq.araddr == `MBS_OFS_STOP_CLAMP) begin
            rdData[`MBS_DLY_W-1:0] = dlyStopClamp_r;
        end else if (axiReq.araddr == `MBS_OFS_CLAMP_OFF) begin
            rdData[`MBS_DLY_W-1:0] = dlyClampOff_r;
        end else if (axiReq.araddr == `MBS_OFS_STATUS) begin
            rdData[`MBS_STAT_RELEASE] = brakeRelease;
            rdData[`MBS_STAT_POWER] = windingPower;
            rdData[`MBS_STAT_PERMIT] = motionPermit;
            rdData[`MBS_STAT_STATE_MSB:`MBS_STAT_STATE_LSB] = state_r;
            rdData[`MBS_STAT_CNT_MSB:`MBS_STAT_CNT_LSB] = elapsed_r;
        end else begin
            rdHit = 1'b0;
        end
    end

    // One read at a time: arready drops while a read answer is pending.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            arRdy_r <= 1'b1;
            rValid_r <= 1'b0;
            rData_r <= '0;
            rResp_r <= `MBS_RESP_OKAY;
        end else if (arRdy_r && axiReq.arvalid) begin
            arRdy_r <= 1'b0;
            rValid_r <= 1'b1;
            rData_r <= rdData;
            rResp_r <= rdHit ? `MBS_RESP_OKAY : `MBS_RESP_SLVERR;
        end else if (rValid_r && axiReq.rready) begin
            arRdy_r <= 1'b1;
            rValid_r <= 1'b0;
        end
    end

    assign axiRsp.awready = !awHeld_r;
    assign axiRsp.wready = !wHeld_r;
    assign axiRsp.bvalid = bValid_r;
    assign axiRsp.bresp = bResp_r;
    assign axiRsp.arready = arRdy_r;
    assign axiRsp.rvalid = rValid_r;
    assign axiRsp.rdata = rData_r;
    assign axiRsp.rresp = rResp_r;
endmodule

/* testbench/mbs_checker.sv */
`timescale 1ns/1ps
module mbs_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire mbs_pkg::mbs_axil_req_t axiReq,
    input wire mbs_pkg::mbs_axil_rsp_t axiRsp,
    input wire logic motorStopped,
    input wire logic brakeRelease,
    input wire logic windingPower,
    input wire logic motionPermit
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence s_aw_take;
        axiReq.awvalid && axiRsp.awready;
    endsequence
    sequence s_w_take;
        axiReq.wvalid && axiRsp.wready;
    endsequence
    sequence s_ar_take;
        axiReq.arvalid && axiRsp.arready;
    endsequence
    a_reset_state: assert property ($fell(rst) |-> !brakeRelease && !windingPower
        && !motionPermit && axiRsp.awready && !axiRsp.bvalid) else $error("bad reset state");
    a_permit_needs_all: assert property (motionPermit |-> brakeRelease && windingPower)
        else $error("motion permitted without release and power");
    a_halt_order: assert property ($fell(motionPermit) |-> brakeRelease && windingPower)
        else $error("brake or power dropped with motion");
    a_clamp_when_stopped: assert property ($fell(brakeRelease) |-> $past(motorStopped)
        && !motionPermit) else $error("brake clamped while motor not at rest");
    a_write_resp: assert property ((s_aw_take and s_w_take) |-> ##[1:3] axiRsp.bvalid)
        else $error("write response missing");
    a_bresp_hold: assert property (axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid
        && $stable(axiRsp.bresp)) else $error("write response dropped early");
    a_rdata_hold: assert property (axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid
        && $stable(axiRsp.rdata) && $stable(axiRsp.rresp)) else $error("read data dropped early");
    a_read_latency: assert property (s_ar_take |=> axiRsp.rvalid && !axiRsp.arready)
        else $error("read answer late");
    a_aw_refused: assert property (s_aw_take |=> !axiRsp.awready)
        else $error("second address accepted while one is held");
endmodule

bind magnetic_brake_sequencer mbs_checker mbs_checker_inst (.clk_sys(clk_sys), .rst(rst),
    .axiReq(axiReq), .axiRsp(axiRsp), .motorStopped(motorStopped),
    .brakeRelease(brakeRelease), .windingPower(windingPower), .motionPermit(motionPermit));

/* testbench/mbs_brake_partner.sv */
`timescale 1ns/1ps
module mbs_brake_partner #(
    parameter int COAST_CYC = 5
) (
    input wire logic clk_sys,
    input wire logic brakeRelease,
    input wire logic motionPermit,
    output logic motorStopped,
    output logic shaftClamped
);
    int coast = 0;
    initial motorStopped = 1'b1;
    // A low level leaves the magnet unpowered, so the spring holds the shaft.
    assign shaftClamped = !brakeRelease;
    // The shaft coasts a few cycles after motion is withdrawn before it is at rest.
    always @(posedge clk_sys) begin
        coast <= motionPermit ? COAST_CYC : (coast > 0 ? coast - 1 : 0);
        motorStopped <= !motionPermit && coast == 0;
    end
endmodule

/* testbench/test_magnetic_brake_sequencer.sv */
`timescale 1ns/1ps
module test_magnetic_brake_sequencer;
    localparam int T = 10;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    mbs_pkg::mbs_axil_req_t axiReq = '0;
    mbs_pkg::mbs_axil_rsp_t axiRsp;
    logic motorStopped, brakeRelease, windingPower, motionPermit, shaftClamped;
    logic [2:0] outs;
    int miscompares = 0;
    int totalChecks = 0;
    int seed = 32'h8BEEB93C;
    int d[4];
    int n;
    logic [31:0] rd;
    logic [1:0] rs;
    assign outs = {motionPermit, windingPower, brakeRelease};

    magnetic_brake_sequencer #(.TICK_CYC(T)) magnetic_brake_sequencer_inst (.clk_sys(clk_sys),
        .rst(rst), .axiReq(axiReq), .axiRsp(axiRsp), .motorStopped(motorStopped),
        .brakeRelease(brakeRelease), .windingPower(windingPower), .motionPermit(motionPermit));
    mbs_brake_partner mbs_brake_partner_inst (.clk_sys(clk_sys), .brakeRelease(brakeRelease),
        .motionPermit(motionPermit), .motorStopped(motorStopped), .shaftClamped(shaftClamped));

    initial forever #50 clk_sys = ~clk_sys;

    task automatic wrapUp();
        $display("checks=%0d miscompares=%0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkRng(input int got, input int lo, input int hi);
        totalChecks++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("[ERR] %0t took %0d cycles, expected %0d..%0d", $time, got, lo, hi);
        end
    endtask

    // One transfer; the response strobe is raised one cycle late to exercise the hold.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        axiReq.awaddr <= a;
        axiReq.araddr <= a;
        axiReq.wdata <= v;
        axiReq.wstrb <= 4'hF;
        axiReq.awvalid <= w;
        axiReq.wvalid <= w;
        axiReq.arvalid <= !w;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (axiRsp.awready === 1'b1) axiReq.awvalid <= 1'b0;
            if (axiRsp.wready === 1'b1) axiReq.wvalid <= 1'b0;
            if (axiRsp.arready === 1'b1) axiReq.arvalid <= 1'b0;
            if ((w ? axiRsp.bvalid : axiRsp.rvalid) === 1'b1) break;
        end
        axiReq.bready <= w;
        axiReq.rready <= !w;
        @(posedge clk_sys);
        rd = axiRsp.rdata;
        rs = w ? axiRsp.bresp : axiRsp.rresp;
        axiReq.bready <= 1'b0;
        axiReq.rready <= 1'b0;
        if (n == 50) miscompares++;
    endtask

    task automatic waitOut(input int k, input logic v, output int c);
        for (c = 0; c < 3000 && outs[k] !== v; c++) @(posedge clk_sys);
    endtask

    initial begin
        #3_000_000;
        miscompares++;
        wrapUp();
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        bus(0, 8'h14, 32'h0);
        chk(rd, 32'hFFFF0100);
        bus(0, 8'h00, 32'h0);
        chk(rd, 32'h3);
        bus(0, 8'h0C, 32'h0);
        chk(rd, 32'hA);
        bus(0, 8'h18, 32'h0);
        chk(rs, 2'h2);
        chk(rd, 32'h0);
        bus(1, 8'h18, 32'h7);
        chk(rs, 2'h2);
        for (int i = 0; i < 4; i++) begin
            d[i] = 2 + ($unsigned($random(seed)) % 3);
            bus(1, 8'h04 + 8'(4 * i), d[i]);
        end
        bus(1, 8'h00, 32'h7);
        waitOut(1, 1'b1, n);
        chk(outs, 3'b010);
        waitOut(0, 1'b1, n);
        chkRng(n, (d[0] - 1) * T - 3, d[0] * T + 3);
        waitOut(2, 1'b1, n);
        chkRng(n, d[1] * T - 3, d[1] * T + 3);
        bus(1, 8'h00, 32'h3);
        waitOut(2, 1'b0, n);
        chk(outs, 3'b011);
        waitOut(0, 1'b0, n);
        chkRng(n, (d[2] - 1) * T, d[2] * T + 12);
        chk(windingPower, 1'b1);
        waitOut(1, 1'b0, n);
        chkRng(n, d[3] * T - 3, d[3] * T + 3);
        bus(1, 8'h00, 32'h2);
        waitOut(0, 1'b1, n);
        chkRng(n, 0, 4);
        bus(1, 8'h00, 32'h3);
        waitOut(0, 1'b0, n);
        chkRng(n, 0, 4);
        bus(1, 8'h0C, 32'hFFFF);
        waitOut(0, 1'b1, n);
        chkRng(n, 0, 4);
        bus(1, 8'h0C, d[2]);
        waitOut(0, 1'b0, n);
        chkRng(n, 0, 4);
        // A clamp delay just above the elapsed time releases, then clamps once it is reached.
        bus(0, 8'h14, 32'h0);
        bus(1, 8'h0C, {16'h0, rd[31:16]} + 32'h3);
        waitOut(0, 1'b1, n);
        chkRng(n, 0, 4);
        waitOut(0, 1'b0, n);
        chkRng(n, T - 4, 3 * T + 4);
        bus(1, 8'h0C, d[2]);
        bus(1, 8'h00, 32'h1);
        waitOut(1, 1'b1, n);
        chkRng(n, 0, 4);
        bus(1, 8'h00, 32'h5);
        waitOut(2, 1'b1, n);
        chkRng(n, (d[1] - 1) * T, d[1] * T + 4);
        bus(1, 8'h00, 32'h1);
        waitOut(0, 1'b0, n);
        repeat ((d[3] + 2) * T) @(posedge clk_sys);
        chk(outs, 3'b010);
        wrapUp();
    end
endmodule
